// >>> common/mbst_pkg.sv
// Behaviour
// - sample inputs on TCK rise, outputs on fall
// - floating TMS reads as one
// - floating TDI shifts in as one
// - TDO driven only in shift states
// - five TMS-high rises reach Test-Logic-Reset
// - no reset pin; resets itself at power-up
// - TMS sequence selects one register at a time
// - registers shift on rise, TDO on fall
// - three-bit instruction governs idle and DR states
// - identification instruction loaded on reset
// - Capture-IR loads 01 into low bits
// - Shift-IR puts instruction register in path
// - new instruction acts only after Update-IR
// - bypass is one flip-flop, one-clock delay
// - boundary register captures pins, shifts in Shift-DR
// - pinless boundary cells always capture one
// - boundary register only for sample/extest instructions
// - identification word captured from constant, shifted
// - identification word shifts out bit 0 first
// - codes 000,001,010,100,111; others private
// - floated-sample forces memory outputs high impedance
package mbst_pkg;

  localparam int IR_W = 3;
  localparam int ID_W = 32;

  typedef enum logic [3:0] {
    ST_TLR    = 4'hf,
    ST_RTI    = 4'hc,
    ST_SEL_DR = 4'h7,
    ST_CAP_DR = 4'h6,
    ST_SH_DR  = 4'h2,
    ST_EX1_DR = 4'h1,
    ST_PAU_DR = 4'h3,
    ST_EX2_DR = 4'h0,
    ST_UPD_DR = 4'h5,
    ST_SEL_IR = 4'h4,
    ST_CAP_IR = 4'he,
    ST_SH_IR  = 4'ha,
    ST_EX1_IR = 4'h9,
    ST_PAU_IR = 4'hb,
    ST_EX2_IR = 4'h8,
    ST_UPD_IR = 4'hd
  } mbst_state_e;

  // instruction codes, msb on the left
  localparam logic [IR_W-1:0] IR_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] IR_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] IR_SAMPLE_Z = 3'h2;
  localparam logic [IR_W-1:0] IR_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;

  // value loaded into the shift stage on Capture-IR
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

  // undriven pins are pulled up, so the tms and tdi synchroniser stages start at one
  localparam logic PIN_IDLE = 1'b1;
  localparam logic BYPASS_CAPTURE = 1'b0;
  localparam logic [3:0] TLR_TMS_COUNT = 4'h5;

endpackage

// >>> core/mbst_bsr.sv
`timescale 1ns/1ps
module mbst_bsr #(
  parameter int W = 8,
  parameter logic [W-1:0] PIN_MASK = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // memory pin levels, asynchronous to clk
  input wire logic [W-1:0] pins,
  // control from the port state machine
  input wire logic cap_en,
  input wire logic sh_en,
  input wire logic upd_en,
  input wire logic sdi,
  // serial end and parallel update stage
  output logic so,
  output logic [W-1:0] upd_q
);
  import mbst_pkg::*;

  logic [W-1:0] pin_s1_r;
  logic [W-1:0] pin_s2_r;
  logic [W-1:0] sh_r;
  logic [W-1:0] cap_val;

  // pins are sampled by clk, not tck; unstable pins give unrepeatable captures
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= pins;
      pin_s2_r <= pin_s1_r;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_cell
      assign cap_val[i] = PIN_MASK[i] ? pin_s2_r[i] : 1'b1;
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sh_r <= '0;
      upd_q <= '0;
    end else begin
      if (cap_en)
        sh_r <= cap_val;
      else if (sh_en)
        sh_r <= {sdi, sh_r[W-1:1]};
      if (upd_en)
        upd_q <= sh_r;
    end
  end

  assign so = sh_r[0];

endmodule

// >>> core/mbst_tap.sv
`timescale 1ns/1ps
module mbst_tap #(
  parameter int BSR_W = 8,
  parameter logic [BSR_W-1:0] BSR_PIN_MASK = 8'h7f,
  // identification constant; value arbitrary, bit 0 set as the protocol asks
  parameter logic [31:0] ID_CODE = 32'h0000_0001
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // test port pins, asynchronous to clk
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // memory pin interface
  input wire logic [BSR_W-1:0] mem_pins,
  output logic [BSR_W-1:0] bsr_drive,
  output logic extest_drive,
  output logic mem_out_hiz
);
  import mbst_pkg::*;

  // synchronisers; stage one is read only by stage two
  logic tck_s1_r;
  logic tck_s2_r;
  logic tck_d_r;
  logic tms_s1_r;
  logic tms_s2_r;
  logic tdi_s1_r;
  logic tdi_s2_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tck_s1_r <= 1'b0;
      tck_s2_r <= 1'b0;
      tck_d_r <= 1'b0;
      tms_s1_r <= PIN_IDLE;
      tms_s2_r <= PIN_IDLE;
      tdi_s1_r <= PIN_IDLE;
      tdi_s2_r <= PIN_IDLE;
    end else begin
      tck_s1_r <= tck;
      tck_s2_r <= tck_s1_r;
      tck_d_r <= tck_s2_r;
      tms_s1_r <= tms;
      tms_s2_r <= tms_s1_r;
      tdi_s1_r <= tdi;
      tdi_s2_r <= tdi_s1_r;
    end
  end

  // edges of the test clock as seen by clk
  wire tck_rise = tck_s2_r & ~tck_d_r;
  wire tck_fall = ~tck_s2_r & tck_d_r;

  function automatic mbst_state_e next_state(input mbst_state_e s, input logic m);
    unique case (s)
      ST_TLR:    next_state = m ? ST_TLR : ST_RTI;
      ST_RTI:    next_state = m ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: next_state = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  next_state = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_state = m ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: next_state = m ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: next_state = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: next_state = m ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: next_state = m ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: next_state = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  next_state = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_state = m ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: next_state = m ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: next_state = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: next_state = m ? ST_SEL_IR : ST_RTI;
    endcase
  endfunction

  mbst_state_e state_r;
  mbst_state_e state_nxt;

  assign state_nxt = next_state(state_r, tms_s2_r);

  // rst_n stands for power-up; no test reset pin exists
  always_ff @(posedge clk) begin
    if (!rst_n)
      state_r <= ST_TLR;
    else if (tck_rise)
      state_r <= state_nxt;
  end

  // register selection
  logic [IR_W-1:0] ir_r;
  logic [IR_W-1:0] ir_sh_r;
  logic bypass_r;
  logic [ID_W-1:0] id_sh_r;
  logic bsr_so;

  wire sel_bsr = (ir_r == IR_EXTEST) || (ir_r == IR_SAMPLE_Z) ||
                 (ir_r == IR_SAMPLE);
  wire sel_id = (ir_r == IR_IDCODE);
  // private and bypass codes both fall to the bypass bit
  wire sel_byp = ~sel_bsr & ~sel_id;

  wire in_cap_dr = tck_rise && (state_r == ST_CAP_DR);
  wire in_sh_dr = tck_rise && (state_r == ST_SH_DR);
  wire in_cap_ir = tck_rise && (state_r == ST_CAP_IR);
  wire in_sh_ir = tck_rise && (state_r == ST_SH_IR);
  wire in_upd_ir = tck_fall && (state_r == ST_UPD_IR);
  wire in_upd_dr = tck_fall && (state_r == ST_UPD_DR);
  wire in_shift = (state_r == ST_SH_DR) || (state_r == ST_SH_IR);

  // instruction register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ir_r <= IR_IDCODE;
      ir_sh_r <= IR_IDCODE;
    end else begin
      if (state_r == ST_TLR)
        ir_r <= IR_IDCODE;
      else if (in_upd_ir)
        ir_r <= ir_sh_r;
      if (in_cap_ir)
        ir_sh_r <= IR_CAPTURE;
      else if (in_sh_ir)
        ir_sh_r <= {tdi_s2_r, ir_sh_r[IR_W-1:1]};
    end
  end

  // bypass and identification
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bypass_r <= BYPASS_CAPTURE;
      id_sh_r <= '0;
    end else begin
      if (in_cap_dr && sel_byp)
        bypass_r <= BYPASS_CAPTURE;
      else if (in_sh_dr && sel_byp)
        bypass_r <= tdi_s2_r;
      if (in_cap_dr && sel_id)
        id_sh_r <= ID_CODE;
      else if (in_sh_dr && sel_id)
        id_sh_r <= {tdi_s2_r, id_sh_r[ID_W-1:1]};
    end
  end

  mbst_bsr #(
    .W(BSR_W),
    .PIN_MASK(BSR_PIN_MASK)
  ) u_bsr (
    .clk(clk),
    .rst_n(rst_n),
    .pins(mem_pins),
    .cap_en(in_cap_dr && sel_bsr),
    .sh_en(in_sh_dr && sel_bsr),
    .upd_en(in_upd_dr && sel_bsr),
    .sdi(tdi_s2_r),
    .so(bsr_so),
    .upd_q(bsr_drive)
  );

  wire dr_so = sel_bsr ? bsr_so : (sel_id ? id_sh_r[0] : bypass_r);
  wire tdo_val = (state_r == ST_SH_IR) ? ir_sh_r[0] : dr_so;

  // test outputs move only on the falling test-clock edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo <= in_shift ? tdo_val : 1'b0;
      tdo_oe <= in_shift;
    end
  end

  // memory-side modes follow the instruction in force
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_out_hiz <= 1'b0;
      extest_drive <= 1'b0;
    end else begin
      mem_out_hiz <= (ir_r == IR_SAMPLE_Z);
      extest_drive <= (ir_r == IR_EXTEST);
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [3:0] ones_cnt_r;
  always_ff @(posedge clk) begin
    if (!rst_n)
      ones_cnt_r <= 4'h0;
    else if (tck_rise)
      ones_cnt_r <= !tms_s2_r ? 4'h0 :
                    (ones_cnt_r < TLR_TMS_COUNT ? ones_cnt_r + 4'h1 : ones_cnt_r);
  end

  a_tlr_after_five: assert property (
    ones_cnt_r == TLR_TMS_COUNT |-> state_r == ST_TLR)
    else $error("five high tms rises did not reach reset state");

  a_ir_reset_id: assert property (
    $past(state_r == ST_TLR) && state_r == ST_TLR |-> ir_r == IR_IDCODE)
    else $error("instruction not identification in reset state");

  a_ir_holds: assert property (
    ir_r != $past(ir_r) |-> $past(state_r == ST_UPD_IR || state_r == ST_TLR))
    else $error("instruction changed outside update or reset");

  a_capture_ir_pat: assert property (
    in_cap_ir |=> ir_sh_r[1:0] == 2'b01)
    else $error("capture-ir pattern wrong");

  a_tdo_on_fall: assert property (
    (tdo != $past(tdo)) || (tdo_oe != $past(tdo_oe)) |-> $past(tck_fall))
    else $error("test output moved off a falling edge");

  // the enable follows the state seen at the fall, so it lingers into exit-1 until then
  a_tdo_only_shift: assert property (
    tck_fall |=> tdo_oe == $past(in_shift))
    else $error("tdo driven outside shift states");

  a_bypass_one: assert property (
    in_sh_dr && sel_byp |=> bypass_r == $past(tdi_s2_r))
    else $error("bypass bit did not take tdi");

  a_id_capture: assert property (
    in_cap_dr && sel_id |=> id_sh_r == ID_CODE)
    else $error("identification word not captured");

  a_id_lsb_out: assert property (
    tck_fall && state_r == ST_SH_DR && sel_id |=> tdo == $past(id_sh_r[0]))
    else $error("identification word not lsb first");

  a_hiz_floated: assert property (
    ir_r == IR_SAMPLE_Z |=> mem_out_hiz)
    else $error("outputs not floated under sample-z");

  a_state_hold: assert property (
    !tck_rise |=> state_r == $past(state_r))
    else $error("state moved without a test-clock rise");

  a_ir_sh_hold: assert property (
    !in_cap_ir && !in_sh_ir |=> ir_sh_r == $past(ir_sh_r))
    else $error("instruction shift stage moved outside capture or shift");

  a_ir_shift_in: assert property (
    in_sh_ir |=> ir_sh_r == {$past(tdi_s2_r), $past(ir_sh_r[IR_W-1:1])})
    else $error("instruction shift stage did not take tdi");

  a_ir_tlr_load: assert property (
    state_r == ST_TLR |=> ir_r == IR_IDCODE)
    else $error("reset state did not load identification code");

  a_ir_update: assert property (
    in_upd_ir |=> ir_r == $past(ir_sh_r))
    else $error("update-ir did not load the shifted code");

  a_bypass_capture: assert property (
    in_cap_dr && sel_byp |=> bypass_r == BYPASS_CAPTURE)
    else $error("bypass bit capture wrong");

  a_id_shift_in: assert property (
    in_sh_dr && sel_id |=> id_sh_r == {$past(tdi_s2_r), $past(id_sh_r[ID_W-1:1])})
    else $error("identification word did not shift");

  a_id_hold: assert property (
    !(in_cap_dr || in_sh_dr) |=> id_sh_r == $past(id_sh_r))
    else $error("identification word moved outside capture or shift");

  a_tdo_ir_lsb: assert property (
    tck_fall && state_r == ST_SH_IR |=> tdo == $past(ir_sh_r[0]))
    else $error("instruction stage not at tdo");

  a_tdo_bypass: assert property (
    tck_fall && state_r == ST_SH_DR && sel_byp |=> tdo == $past(bypass_r))
    else $error("bypass bit not at tdo");

  a_tdo_boundary: assert property (
    tck_fall && state_r == ST_SH_DR && sel_bsr |=> tdo == $past(bsr_so))
    else $error("boundary register not at tdo");

  a_tdo_idle_low: assert property (
    tck_fall && !in_shift |=> !tdo && !tdo_oe)
    else $error("tdo not released outside shift states");

  a_extest_follow: assert property (
    extest_drive == $past(ir_r == IR_EXTEST))
    else $error("external-test drive does not follow instruction");

  a_hiz_follow: assert property (
    mem_out_hiz == $past(ir_r == IR_SAMPLE_Z))
    else $error("output float does not follow instruction");

  a_bsr_drive_hold: assert property (
    !(in_upd_dr && sel_bsr) |=> bsr_drive == $past(bsr_drive))
    else $error("boundary update stage moved without update-dr");

  a_go_idle: assert property (
    tck_rise && state_r == ST_TLR && !tms_s2_r |=> state_r == ST_RTI)
    else $error("reset state did not go to idle");

  a_go_sel_dr: assert property (
    tck_rise && state_r == ST_RTI && tms_s2_r |=> state_r == ST_SEL_DR)
    else $error("idle did not go to select-dr");

  a_go_cap_dr: assert property (
    tck_rise && state_r == ST_SEL_DR && !tms_s2_r |=> state_r == ST_CAP_DR)
    else $error("select-dr did not go to capture-dr");

  a_go_sel_ir: assert property (
    tck_rise && state_r == ST_SEL_DR && tms_s2_r |=> state_r == ST_SEL_IR)
    else $error("select-dr did not go to select-ir");

  a_go_reset: assert property (
    tck_rise && state_r == ST_SEL_IR && tms_s2_r |=> state_r == ST_TLR)
    else $error("select-ir did not go to reset state");

  a_go_shift_dr: assert property (
    tck_rise && state_r == ST_CAP_DR && !tms_s2_r |=> state_r == ST_SH_DR)
    else $error("capture-dr did not go to shift-dr");

  a_go_exit_dr: assert property (
    tck_rise && state_r == ST_SH_DR && tms_s2_r |=> state_r == ST_EX1_DR)
    else $error("shift-dr did not go to exit-dr");

  a_go_upd_dr: assert property (
    tck_rise && state_r == ST_EX1_DR && tms_s2_r |=> state_r == ST_UPD_DR)
    else $error("exit-dr did not go to update-dr");

  a_upd_dr_idle: assert property (
    tck_rise && state_r == ST_UPD_DR && !tms_s2_r |=> state_r == ST_RTI)
    else $error("update-dr did not go to idle");

  a_upd_ir_idle: assert property (
    tck_rise && state_r == ST_UPD_IR && !tms_s2_r |=> state_r == ST_RTI)
    else $error("update-ir did not go to idle");

  a_sh_ir_stay: assert property (
    tck_rise && state_r == ST_SH_IR && !tms_s2_r |=> state_r == ST_SH_IR)
    else $error("shift-ir did not hold");

  c_tlr_entry: cover property (tck_rise && state_r == ST_SEL_IR && tms_s2_r);
  c_id_shift: cover property (in_sh_dr && sel_id);
  c_ir_update: cover property (in_upd_ir);
  c_samplez: cover property (mem_out_hiz);
  c_bsr_shift: cover property (in_sh_dr && sel_bsr);

endmodule

// >>> verification/mbst_ctl.sv
`timescale 1ns/1ps
module mbst_ctl (
  // system clock
  input wire logic clk,
  // test port
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  logic oe_and;
  // tdo_oe as seen at every shifting rise of the last scan
  logic oe_shift;

  // released lines sit at the pad pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    oe_and = 1'b1;
    oe_shift = 1'b0;
  end

  // one test clock of 8 clk; tdo is taken just after the rise, where it has settled
  task automatic step(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    #1 q = tdo;
    oe_and = oe_and & tdo_oe;
    repeat (4) @(posedge clk);
    tck <= 1'b0;
  endtask

  // tck then stands low between frames
  task automatic go_idle();
    logic q;
    step(1'b0, 1'b1, q);
    @(posedge clk);
    tms <= 1'b1;
    tdi <= 1'b1;
    @(posedge clk);
  endtask

  task automatic reset5();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    go_idle();
  endtask

  // idle to idle; the ir path takes one more select step
  task automatic scan(input logic ir, input int n, input logic [39:0] din,
                      output logic [39:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir) begin
      step(1'b1, 1'b1, q);
    end
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    oe_and = 1'b1;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    oe_shift = oe_and;
    step(1'b1, 1'b1, q);
    go_idle();
  endtask
endmodule

// >>> verification/mbst_tap_tb_top.sv
`timescale 1ns/1ps
module mbst_tap_tb_top;
  import mbst_pkg::*;
  // arbitrary identification value, bit 0 set
  localparam logic [31:0] ID = 32'h5a3c_96e1;
  localparam int LIMIT = 20000;
  logic clk, rst_n, tck, tms, tdi, tdo, tdo_oe, extest_drive, mem_out_hiz;
  logic [7:0] mem_pins, bsr_drive;
  logic [39:0] dout;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;

  mbst_tap #(.ID_CODE(ID)) mbst_tap_i (
    .clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .mem_pins(mem_pins), .bsr_drive(bsr_drive),
    .extest_drive(extest_drive), .mem_out_hiz(mem_out_hiz)
  );
  mbst_ctl mbst_ctl_i (
    .clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // shifting past 32 bits shows tdi coming back out behind the word
  task automatic t_id();
    mbst_ctl_i.scan(1'b0, 40, 40'hc3, dout);
    chk(dout, {8'hc3, ID});
    chk(40'(mbst_ctl_i.oe_shift), 40'h1);
    chk(40'(tdo_oe), 40'h0);
    $display("test id done");
  endtask

  task automatic t_byp();
    logic [2:0] codes [4] = '{IR_BYPASS, 3'h3, 3'h5, 3'h6};
    foreach (codes[k]) begin
      mbst_ctl_i.scan(1'b1, 3, 40'(codes[k]), dout);
      chk(dout, 40'(IR_CAPTURE));
      mbst_ctl_i.scan(1'b0, 8, 40'ha5, dout);
      chk(dout, 40'h4a);
    end
    $display("test bypass done");
  endtask

  task automatic t_bsr();
    logic [2:0] codes [3] = '{IR_SAMPLE, IR_SAMPLE_Z, IR_EXTEST};
    logic [7:0] p;
    foreach (codes[k]) begin
      p = 8'h34 | 8'(k);
      mem_pins <= p;
      mbst_ctl_i.scan(1'b1, 3, 40'(codes[k]), dout);
      chk(40'(mem_out_hiz), 40'(codes[k] == IR_SAMPLE_Z));
      chk(40'(extest_drive), 40'(codes[k] == IR_EXTEST));
      mbst_ctl_i.scan(1'b0, 8, 40'h96, dout);
      chk(dout, 40'(p | 8'h80));
      chk(40'(bsr_drive), 40'h96);
    end
    $display("test boundary done");
  endtask

  // a floated-sample code must be dropped by the five-ones reset
  task automatic t_tlr();
    mbst_ctl_i.scan(1'b1, 3, 40'(IR_SAMPLE_Z), dout);
    chk(40'(mem_out_hiz), 40'h1);
    mbst_ctl_i.reset5();
    chk(40'(mem_out_hiz), 40'h0);
    t_id();
    $display("test reset done");
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    mem_pins = 8'h00;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    mbst_ctl_i.go_idle();
    t_id();
    t_byp();
    t_bsr();
    t_tlr();
    end_of_test();
  end
endmodule
